// [verilog/gmd_cfg.svh]
// address map constants of the graphics register decoder
`ifndef GMD_CFG_SVH
`define GMD_CFG_SVH
// region boundaries, each the first offset of its region
`define GMD_B_RSV0    20'h01000
`define GMD_B_CS      20'h02000
`define GMD_B_FENCE   20'h03000
`define GMD_B_FBC     20'h03200
`define GMD_B_RSV1    20'h04000
`define GMD_B_IOCTL   20'h05000
`define GMD_B_CLK     20'h06000
`define GMD_B_DBG3D   20'h07000
`define GMD_B_DBGFF   20'h07400
`define GMD_B_RSV2    20'h08900
`define GMD_B_PAL     20'h0a000
`define GMD_B_RSV3    20'h0b000
`define GMD_B_MCH     20'h10000
`define GMD_B_RSV4    20'h14000
`define GMD_B_OVL     20'h30000
`define GMD_B_RSV5    20'h40000
`define GMD_B_PIPE    20'h60000
`define GMD_B_PLANE   20'h70000
`define GMD_B_PERF    20'h73000
`define GMD_B_RSV6    20'h74000
`define GMD_MMIO_SIZE 32'h0008_0000
// i/o space: legacy vga ports and the index/data pair
`define GMD_VGA_PORT_LO 16'h03b0
`define GMD_VGA_PORT_HI 16'h03df
`define GMD_IO_INDEX    16'h0000
`define GMD_IO_DATA     16'h0004
// local command streamer bank
`define GMD_CS_LOCAL_HI 20'h0220f
`define GMD_CS_WORDS    132
`define GMD_W_LSB       2
`define GMD_W_MSB       9
`define GMD_EXEC_CONDITION_CODE_WMASK  32'h0000_ffff
`define GMD_DWM_LSB     0
`define GMD_DWM_MSB     5
`define GMD_DBL_LSB     8
`define GMD_DBL_MSB     9
// register offsets of the local bank
`define GMD_O_PT_CTL     20'h02020
`define GMD_O_PT_ERR     20'h02024
`define GMD_O_EXEC_CONDITION_CODE       20'h02028
`define GMD_O_R0_TAIL    20'h02030
`define GMD_O_R0_HEAD    20'h02034
`define GMD_O_R0_START   20'h02038
`define GMD_O_R0_CTL     20'h0203c
`define GMD_O_MEMRD      20'h02060
`define GMD_O_PERR_ID    20'h02064
`define GMD_O_PERR_HDR   20'h02068
`define GMD_O_SI_DONE    20'h0206c
`define GMD_O_P_STATE    20'h02070
`define GMD_O_ACT_HEAD   20'h02074
`define GMD_O_FETCH      20'h02078
`define GMD_O_SI_DONE_B  20'h0207c
`define GMD_O_HWS_PAGE   20'h02080
`define GMD_O_PWR_CTX    20'h02088
`define GMD_O_NOOP_ID    20'h02094
`define GMD_O_HWS_MASK   20'h02098
`define GMD_O_SW_MODE    20'h0209c
`define GMD_O_IER        20'h020a0
`define GMD_O_IIR        20'h020a4
`define GMD_O_IMR        20'h020a8
`define GMD_O_ISR        20'h020ac
`define GMD_O_EIR        20'h020b0
`define GMD_O_EMR        20'h020b4
`define GMD_O_ESR        20'h020b8
`define GMD_O_P_MODE     20'h020c0
`define GMD_O_PPT_CTL    20'h020c4
`define GMD_O_PPT_STEER  20'h020c8
`define GMD_O_DISP_CTL   20'h020d0
`define GMD_O_DPD_EN     20'h020e0
`define GMD_O_ARB        20'h020e4
`define GMD_O_RDRET      20'h020fc
`define GMD_O_BATCH_BUFFER_STATE   20'h02110
`define GMD_O_CACHE0     20'h02120
`define GMD_O_CACHE1     20'h02124
`define GMD_O_PEND_HEAD  20'h02134
`define GMD_O_BATCH_CURRENT_ADDRESS_LO 20'h02140
`define GMD_O_BATCH_CURRENT_ADDRESS_HI 20'h02144
`define GMD_O_FLUSH_LO   20'h02170
`define GMD_O_FLUSH_HI   20'h02174
`define GMD_O_WD_CTL     20'h02178
`define GMD_O_WD_THRESH  20'h0217c
`define GMD_O_CTX_ID0    20'h02180
`define GMD_O_WD_COUNT   20'h02190
`define GMD_O_CTX_SIZE   20'h021a0
`define GMD_O_CTX_SZ_NX  20'h021a4
`define GMD_O_SCRATCH    20'h021d0
`define GMD_O_FL_FSM     20'h02200
`define GMD_O_FL_FLAG    20'h02204
`endif

// [verilog/gmd_pkg.sv]
// shared types of the graphics register decoder
`include "gmd_cfg.svh"
package gmd_pkg;
    typedef enum logic [3:0] {
        GMD_R_VGA, GMD_R_CS, GMD_R_FENCE, GMD_R_FBC, GMD_R_IOCTL,
        GMD_R_CLK, GMD_R_DBG3D, GMD_R_DBGFF, GMD_R_PAL, GMD_R_MCH,
        GMD_R_OVL, GMD_R_PIPE, GMD_R_PLANE, GMD_R_PERF, GMD_R_RSVD
    } gmd_region_t;
    typedef enum logic [2:0] {
        GMD_A_NONE, GMD_A_RW, GMD_A_RO, GMD_A_MIXED, GMD_A_W1C
    } gmd_acc_t;
    typedef enum logic [1:0] {
        GMD_K_NONE, GMD_K_LOCAL, GMD_K_FWD, GMD_K_INDEX
    } gmd_kind_t;
    typedef enum logic [1:0] {
        GMD_S_IDLE = 2'b01, GMD_S_ACCESS = 2'b10
    } gmd_fsm_t;
    typedef struct packed {
        logic        io;
        logic        we;
        logic [3:0]  be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } gmd_req_t;
    typedef struct packed {
        logic        valid;
        logic        we;
        logic [3:0]  be;
        gmd_region_t region;
        logic [19:0] offset;
        logic [31:0] wdata;
    } gmd_fwd_t;
    typedef struct packed {
        logic        valid;
        logic [7:0]  word;
        logic [31:0] data;
    } gmd_hw_upd_t;
    typedef struct packed {
        gmd_fsm_t                         fsm;
        gmd_kind_t                        kind;
        logic [31:0]                      index;
        logic [19:0]                      ofs;
        logic                             we;
        logic [3:0]                       be;
        logic [31:0]                      wdata;
        logic                             rsp_valid;
        logic [31:0]                      rdata;
        gmd_fwd_t                         fwd;
        logic [`GMD_CS_WORDS-1:0][31:0]   store;
    } gmd_st_t;
endpackage

// [verilog/gmd_w1c.sv]
// sticky event bits: set by hardware, cleared by writing one
`timescale 1ns/10ps
module gmd_w1c (
    input  wire logic [31:0] cur,
    input  wire logic [31:0] set,
    input  wire logic [31:0] clr,
    output logic [31:0]      nxt
);
    // a set arriving with its clear keeps the bit
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            assign nxt[i] = set[i] | (cur[i] & ~clr[i]);
        end
    endgenerate
endmodule

// [verilog/gmd_region_dec.sv]
// steers a register offset to its functional region
`timescale 1ns/10ps
`include "gmd_cfg.svh"
module gmd_region_dec (
    input  wire logic [19:0]      ofs,
    output gmd_pkg::gmd_region_t  region
);
    // boundaries checked from the top down
    always_comb begin
        region = gmd_pkg::GMD_R_RSVD;
        if (ofs >= `GMD_B_RSV6) region = gmd_pkg::GMD_R_RSVD;
        else if (ofs >= `GMD_B_PERF) region = gmd_pkg::GMD_R_PERF;
        else if (ofs >= `GMD_B_PLANE) region = gmd_pkg::GMD_R_PLANE;
        else if (ofs >= `GMD_B_PIPE) region = gmd_pkg::GMD_R_PIPE;
        else if (ofs >= `GMD_B_RSV5) region = gmd_pkg::GMD_R_RSVD;
        else if (ofs >= `GMD_B_OVL) region = gmd_pkg::GMD_R_OVL;
        else if (ofs >= `GMD_B_RSV4) region = gmd_pkg::GMD_R_RSVD;
        else if (ofs >= `GMD_B_MCH) region = gmd_pkg::GMD_R_MCH;
        else if (ofs >= `GMD_B_RSV3) region = gmd_pkg::GMD_R_RSVD;
        else if (ofs >= `GMD_B_PAL) region = gmd_pkg::GMD_R_PAL;
        else if (ofs >= `GMD_B_RSV2) region = gmd_pkg::GMD_R_RSVD;
        else if (ofs >= `GMD_B_DBGFF) region = gmd_pkg::GMD_R_DBGFF;
        else if (ofs >= `GMD_B_DBG3D) region = gmd_pkg::GMD_R_DBG3D;
        else if (ofs >= `GMD_B_CLK) region = gmd_pkg::GMD_R_CLK;
        else if (ofs >= `GMD_B_IOCTL) region = gmd_pkg::GMD_R_IOCTL;
        else if (ofs >= `GMD_B_RSV1) region = gmd_pkg::GMD_R_RSVD;
        else if (ofs >= `GMD_B_FBC) region = gmd_pkg::GMD_R_FBC;
        else if (ofs >= `GMD_B_FENCE) region = gmd_pkg::GMD_R_FENCE;
        else if (ofs >= `GMD_B_CS) region = gmd_pkg::GMD_R_CS;
        else if (ofs >= `GMD_B_RSV0) region = gmd_pkg::GMD_R_RSVD;
        else region = gmd_pkg::GMD_R_VGA;
    end
endmodule

// [verilog/gmd_decoder.sv]
// graphics register address decoder with command streamer bank
`timescale 1ns/10ps
`include "gmd_cfg.svh"
module gmd_decoder (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [31:0]           mmio_base,
    input  wire logic [15:0]           io_base,
    input  wire logic                  req_valid,
    input  wire gmd_pkg::gmd_req_t     req,
    output logic                       req_ready,
    output logic                       rsp_valid,
    output logic [31:0]                rsp_rdata,
    output gmd_pkg::gmd_fwd_t          fwd,
    input  wire logic [31:0]           fwd_rdata,
    input  wire gmd_pkg::gmd_hw_upd_t  hw_upd,
    input  wire logic [31:0]           intr_set,
    input  wire logic [31:0]           err_set,
    input  wire logic                  ctx_restore,
    input  wire logic [31:0]           ctx_arb_data,
    output logic [31:0]                ctx_arb_state,
    output logic [5:0]                 disp_watermark,
    output logic [1:0]                 disp_burst
);

    // word positions of the registers with side effects
    localparam logic [7:0] IIR_W =
        8'((`GMD_O_IIR - `GMD_B_CS) >> `GMD_W_LSB);
    localparam logic [7:0] EIR_W =
        8'((`GMD_O_EIR - `GMD_B_CS) >> `GMD_W_LSB);
    localparam logic [7:0] ARB_W =
        8'((`GMD_O_ARB - `GMD_B_CS) >> `GMD_W_LSB);
    localparam logic [7:0] DISP_W =
        8'((`GMD_O_DISP_CTL - `GMD_B_CS) >> `GMD_W_LSB);
    localparam logic [7:0] WORDS = 8'(`GMD_CS_WORDS);

    gmd_pkg::gmd_st_t      st_q;
    gmd_pkg::gmd_st_t      st_d;
    logic [31:0]           mem_ofs;
    logic [19:0]           mem_ofs20;
    logic [15:0]           io_port;
    logic [15:0]           io_rel;
    logic [19:0]           idx_ofs;
    logic                  vga_port;
    logic                  io_data;
    logic                  sel_index;
    logic                  sel_hit;
    logic [19:0]           sel_ofs;
    gmd_pkg::gmd_region_t  sel_region;
    gmd_pkg::gmd_kind_t    sel_kind;
    logic                  taken;
    logic [7:0]            acc_w;
    gmd_pkg::gmd_acc_t     acc_cls;
    logic [31:0]           acc_mask;
    logic [19:0]           hw_ofs;
    logic [31:0]           iir_clr;
    logic [31:0]           eir_clr;
    logic [31:0]           iir_nxt;
    logic [31:0]           eir_nxt;

    // access class of each word in the local bank
    function automatic gmd_pkg::gmd_acc_t cs_class(
        input logic [19:0] o
    );
        gmd_pkg::gmd_acc_t c;
        case (o)
            `GMD_O_PT_CTL, `GMD_O_R0_TAIL, `GMD_O_R0_HEAD,
            `GMD_O_R0_START, `GMD_O_R0_CTL, `GMD_O_HWS_PAGE,
            `GMD_O_PWR_CTX, `GMD_O_HWS_MASK, `GMD_O_SW_MODE,
            `GMD_O_IER, `GMD_O_IMR, `GMD_O_EMR, `GMD_O_P_MODE,
            `GMD_O_PPT_CTL, `GMD_O_PPT_STEER, `GMD_O_DISP_CTL,
            `GMD_O_DPD_EN, `GMD_O_ARB, `GMD_O_RDRET,
            `GMD_O_BATCH_BUFFER_STATE, `GMD_O_CACHE0, `GMD_O_CACHE1,
            `GMD_O_PEND_HEAD, `GMD_O_FLUSH_LO, `GMD_O_FLUSH_HI,
            `GMD_O_WD_CTL, `GMD_O_WD_THRESH, `GMD_O_CTX_ID0,
            `GMD_O_CTX_SIZE, `GMD_O_CTX_SZ_NX, `GMD_O_SCRATCH,
            `GMD_O_FL_FSM, `GMD_O_FL_FLAG: begin
                c = gmd_pkg::GMD_A_RW;
            end
            `GMD_O_PT_ERR, `GMD_O_MEMRD, `GMD_O_PERR_ID,
            `GMD_O_PERR_HDR, `GMD_O_SI_DONE, `GMD_O_P_STATE,
            `GMD_O_ACT_HEAD, `GMD_O_FETCH, `GMD_O_SI_DONE_B,
            `GMD_O_NOOP_ID, `GMD_O_ISR, `GMD_O_ESR,
            `GMD_O_BATCH_CURRENT_ADDRESS_LO, `GMD_O_BATCH_CURRENT_ADDRESS_HI,
            `GMD_O_WD_COUNT: begin
                c = gmd_pkg::GMD_A_RO;
            end
            `GMD_O_EXEC_CONDITION_CODE: begin
                c = gmd_pkg::GMD_A_MIXED;
            end
            `GMD_O_IIR, `GMD_O_EIR: begin
                c = gmd_pkg::GMD_A_W1C;
            end
            default: begin
                c = gmd_pkg::GMD_A_NONE;
            end
        endcase
        return c;
    endfunction

    // byte enables spread to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // offset of the incoming request for each access path
    always_comb begin
        mem_ofs = req.addr - mmio_base;
        mem_ofs20 = mem_ofs[19:0];
        io_port = req.addr[15:0];
        io_rel = io_port - io_base;
        idx_ofs = st_q.index[19:0];
        vga_port = req.io && io_port >= `GMD_VGA_PORT_LO &&
                   io_port <= `GMD_VGA_PORT_HI;
        io_data = 1'b0;
        sel_index = 1'b0;
        sel_ofs = mem_ofs20;
        sel_hit = !req.io && req.addr >= mmio_base &&
                  mem_ofs < `GMD_MMIO_SIZE;
        if (vga_port) begin
            sel_ofs = {4'h0, io_port};
            sel_hit = 1'b1;
        end else if (req.io && io_rel == `GMD_IO_INDEX) begin
            sel_index = 1'b1;
            sel_hit = 1'b0;
        end else if (req.io && io_rel == `GMD_IO_DATA) begin
            io_data = 1'b1;
            sel_ofs = idx_ofs;
            sel_hit = st_q.index < `GMD_MMIO_SIZE;
        end else if (req.io) begin
            sel_hit = 1'b0;
        end
    end

    gmd_region_dec u_region (
        .ofs    (sel_ofs),
        .region (sel_region)
    );

    // what the accepted request will do
    always_comb begin
        if (sel_index) begin
            sel_kind = gmd_pkg::GMD_K_INDEX;
        end else if (!sel_hit ||
                     sel_region == gmd_pkg::GMD_R_RSVD) begin
            sel_kind = gmd_pkg::GMD_K_NONE;
        end else if (sel_region == gmd_pkg::GMD_R_OVL &&
                     req.we) begin
            sel_kind = gmd_pkg::GMD_K_NONE;
        end else if (sel_region == gmd_pkg::GMD_R_CS &&
                     sel_ofs <= `GMD_CS_LOCAL_HI) begin
            sel_kind = gmd_pkg::GMD_K_LOCAL;
        end else begin
            sel_kind = gmd_pkg::GMD_K_FWD;
        end
    end

    // local bank word under access and its write clears
    always_comb begin
        acc_w = st_q.ofs[`GMD_W_MSB:`GMD_W_LSB];
        acc_cls = cs_class(st_q.ofs);
        acc_mask = be_mask(st_q.be);
        hw_ofs = `GMD_B_CS | {10'h000, hw_upd.word, 2'b00};
        iir_clr = 32'h0000_0000;
        eir_clr = 32'h0000_0000;
        if (st_q.fsm == gmd_pkg::GMD_S_ACCESS &&
            st_q.kind == gmd_pkg::GMD_K_LOCAL && st_q.we) begin
            if (st_q.ofs == `GMD_O_IIR) begin
                iir_clr = st_q.wdata & acc_mask;
            end
            if (st_q.ofs == `GMD_O_EIR) begin
                eir_clr = st_q.wdata & acc_mask;
            end
        end
    end

    gmd_w1c u_iir (
        .cur (st_q.store[IIR_W]),
        .set (intr_set),
        .clr (iir_clr),
        .nxt (iir_nxt)
    );

    gmd_w1c u_eir (
        .cur (st_q.store[EIR_W]),
        .set (err_set),
        .clr (eir_clr),
        .nxt (eir_nxt)
    );

    // next state of the decoder and its register bank
    always_comb begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;
        st_d.fwd.valid = 1'b0;
        st_d.store[IIR_W] = iir_nxt;
        st_d.store[EIR_W] = eir_nxt;
        if (hw_upd.valid && hw_upd.word < WORDS &&
            cs_class(hw_ofs) == gmd_pkg::GMD_A_RO) begin
            st_d.store[hw_upd.word] = hw_upd.data;
        end
        if (ctx_restore) begin
            st_d.store[ARB_W] = ctx_arb_data;
        end
        case (st_q.fsm)
            gmd_pkg::GMD_S_IDLE: begin
                if (req_valid) begin
                    st_d.fsm = gmd_pkg::GMD_S_ACCESS;
                    st_d.kind = sel_kind;
                    st_d.ofs = sel_ofs;
                    st_d.we = req.we;
                    st_d.be = req.be;
                    st_d.wdata = req.wdata;
                    // vga sets keep their own index/data pairs
                    st_d.fwd.valid =
                        sel_kind == gmd_pkg::GMD_K_FWD;
                    st_d.fwd.we = req.we;
                    st_d.fwd.be = req.be;
                    st_d.fwd.region = sel_region;
                    st_d.fwd.offset = sel_ofs;
                    st_d.fwd.wdata = req.wdata;
                end
            end
            gmd_pkg::GMD_S_ACCESS: begin
                st_d.fsm = gmd_pkg::GMD_S_IDLE;
                st_d.rsp_valid = 1'b1;
                st_d.rdata = 32'h0000_0000;
                case (st_q.kind)
                    gmd_pkg::GMD_K_FWD: begin
                        if (!st_q.we) begin
                            st_d.rdata = fwd_rdata;
                        end
                    end
                    gmd_pkg::GMD_K_INDEX: begin
                        if (st_q.we) begin
                            st_d.index = (st_q.index & ~acc_mask) |
                                         (st_q.wdata & acc_mask);
                        end else begin
                            st_d.rdata = st_q.index;
                        end
                    end
                    gmd_pkg::GMD_K_LOCAL: begin
                        case (acc_cls)
                            gmd_pkg::GMD_A_RW: begin
                                if (st_q.we) begin
                                    st_d.store[acc_w] =
                                        (st_q.store[acc_w] & ~acc_mask) |
                                        (st_q.wdata & acc_mask);
                                end
                            end
                            gmd_pkg::GMD_A_MIXED: begin
                                if (st_q.we) begin
                                    st_d.store[acc_w] =
                                        (st_q.store[acc_w] &
                                         ~(acc_mask & `GMD_EXEC_CONDITION_CODE_WMASK)) |
                                        (st_q.wdata & acc_mask &
                                         `GMD_EXEC_CONDITION_CODE_WMASK);
                                end
                            end
                            default: begin
                            end
                        endcase
                        if (!st_q.we &&
                            acc_cls != gmd_pkg::GMD_A_NONE) begin
                            st_d.rdata = st_q.store[acc_w];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                st_d.fsm = gmd_pkg::GMD_S_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.fsm <= gmd_pkg::GMD_S_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign taken = req_valid && req_ready;
    assign req_ready = st_q.fsm == gmd_pkg::GMD_S_IDLE;
    assign rsp_valid = st_q.rsp_valid;
    assign rsp_rdata = st_q.rdata;
    assign fwd = st_q.fwd;
    assign ctx_arb_state = st_q.store[ARB_W];
    assign disp_watermark =
        st_q.store[DISP_W][`GMD_DWM_MSB:`GMD_DWM_LSB];
    assign disp_burst =
        st_q.store[DISP_W][`GMD_DBL_MSB:`GMD_DBL_LSB];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_VGA_MEM_ROUTE: assert property (
        taken && !req.io && sel_kind == gmd_pkg::GMD_K_FWD &&
        sel_region == gmd_pkg::GMD_R_VGA |=>
        fwd.valid && fwd.region == gmd_pkg::GMD_R_VGA)
        else $error("vga memory access not forwarded to vga");

    AST_VGA_PORT_SAME: assert property (
        taken && vga_port |=>
        fwd.valid && fwd.offset == {4'h0, $past(io_port)})
        else $error("vga port and memory offset differ");

    AST_IO_DATA_PATH: assert property (
        taken && io_data && sel_kind == gmd_pkg::GMD_K_FWD |=>
        fwd.valid && fwd.offset == $past(idx_ofs))
        else $error("data port did not use the index");

    AST_INDEX_LOAD: assert property (
        taken && sel_index && req.we && req.be == 4'hf |->
        ##2 st_q.index == $past(req.wdata, 2))
        else $error("index port write lost");

    AST_MMIO_OFFSET: assert property (
        taken && !req.io && sel_kind == gmd_pkg::GMD_K_FWD |=>
        fwd.offset == $past(mem_ofs20))
        else $error("memory offset not relative to base");

    AST_CS_LOCAL: assert property (
        taken && sel_kind == gmd_pkg::GMD_K_LOCAL |=>
        !fwd.valid ##1 rsp_valid)
        else $error("local bank access mishandled");

    AST_MCH_ALIAS: assert property (
        sel_ofs >= `GMD_B_MCH && sel_ofs < `GMD_B_RSV4 |->
        sel_region == gmd_pkg::GMD_R_MCH)
        else $error("memory controller alias not decoded");

    AST_OVL_REFUSE: assert property (
        fwd.valid && fwd.region == gmd_pkg::GMD_R_OVL |->
        !fwd.we)
        else $error("overlay write reached the chip copy");

    AST_ARB_RESTORE: assert property (
        ctx_restore && st_q.fsm == gmd_pkg::GMD_S_IDLE |=>
        ctx_arb_state == $past(ctx_arb_data))
        else $error("arbitration state not restored");

    AST_RSV_ZERO: assert property (
        taken && sel_kind == gmd_pkg::GMD_K_NONE && !req.we |->
        ##2 rsp_valid && rsp_rdata == 32'h0000_0000)
        else $error("reserved read not zero");

endmodule

// [sim/gmd_region_model.sv]
// region side model answering forwarded accesses in their own cycle
`timescale 1ns/10ps
module gmd_region_model (
    input  wire gmd_pkg::gmd_fwd_t fwd,
    output logic [31:0]            rdata
);
    // answer carries region and offset; inverted while no access
    always_comb begin
        rdata = {8'ha5, fwd.region, fwd.offset};
        if (fwd.valid !== 1'b1) begin
            rdata = ~rdata;
        end
    end
endmodule

// [sim/gmd_decoder_bench.sv]
// self-checking bench of the graphics register decoder
`timescale 1ns/10ps
module gmd_decoder_bench;
    logic              clk, rst, req_valid, req_ready, rsp_valid, ctx_rs;
    logic [31:0]       rsp_rdata, fwd_rdata, arb_d, arb_state, r, n, iset;
    logic [5:0]        wmark;
    logic [1:0]        burst;
    gmd_pkg::gmd_req_t req;
    gmd_pkg::gmd_fwd_t fwd;
    logic [32:0]       exp_q[$];
    int                err_total, tests_run, n_fwd;
    localparam logic [31:0] MB = 32'hc000_0000;
    localparam logic [23:0] TB [21] = '{24'h102210, 24'h203000, 24'h2031fc,
        24'h303200, 24'h303ffc, 24'h506000, 24'h506ffc, 24'h707400,
        24'h7088fc, 24'h910000, 24'h913ffc, 24'ha30000, 24'hb60000,
        24'hb6fffc, 24'hc70000, 24'hc72ffc, 24'he01000, 24'he08900,
        24'he14000, 24'he40000, 24'he74000};
    gmd_decoder uut (.clk(clk), .rst(rst), .mmio_base(MB),
        .io_base(16'h1000), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .fwd(fwd), .fwd_rdata(fwd_rdata),
        .hw_upd('0), .intr_set(iset), .err_set(32'h0),
        .ctx_restore(ctx_rs), .ctx_arb_data(arb_d),
        .ctx_arb_state(arb_state), .disp_watermark(wmark),
        .disp_burst(burst));
    gmd_region_model far (.fwd(fwd), .rdata(fwd_rdata));
    function logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task acc(input logic isio, we, input logic [31:0] a, d, e);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{io: isio, we: we, be: 4'hf, addr: a, wdata: d};
        exp_q.push_back({!we, e});
        @(posedge clk);
        // hold the request until the edge that samples ready high
        while (req_ready !== 1'b1) begin
            @(posedge clk);
        end
        req_valid <= 1'b0;
        @(negedge clk);
        chk(req_ready, 32'h0);
        repeat (2) @(posedge clk);
    endtask
    task complete_run;
        if (exp_q.size() != 0) begin
            err_total++;
            $display("Error at %0t: response missing", $time);
        end
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // clock of 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // response watcher: oldest note against each read answer, fwd pulse count
    always @(posedge clk) begin
        if (fwd.valid === 1'b1) n_fwd++;
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("Error at %0t: response without request", $time);
            end else begin
                if (exp_q[0][32]) chk(rsp_rdata, exp_q[0][31:0]);
                void'(exp_q.pop_front());
            end
        end
    end
    // watchdog cuts a hang short
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        complete_run();
    end
    // main sequence
    initial begin
        {rst, req_valid, req, ctx_rs, arb_d, iset} = '0;
        rst = 1'b1;
        {err_total, tests_run, n_fwd, r} = {32'h0, 32'h0, 32'h0, 32'h13a9};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            acc(0, 0, MB + TB[i][19:0], 0, {8'ha5, TB[i]});
        end
        for (int i = 9; i < 21; i++) begin
            n = (TB[i][23:20] == 4'he) ? 32'h0 : {8'ha5, TB[i]};
            acc(0, 0, MB + TB[i][19:0], 0, n);
        end
        acc(0, 0, MB - 4, 0, 0);
        $display("regions done");
        acc(1, 0, 32'h3c4, 0, 32'ha50003c4);
        acc(0, 0, MB + 32'h3c4, 0, 32'ha50003c4);
        r = xs(r);
        acc(0, 1, MB + 32'h2030, r, 0);
        acc(0, 0, MB + 32'h2030, 0, r);
        acc(1, 1, 32'h1000, 32'h2034, 0);
        acc(1, 1, 32'h1004, ~r, 0);
        acc(0, 0, MB + 32'h2034, 0, ~r);
        acc(1, 1, 32'h1000, 32'h6000, 0);
        acc(1, 0, 32'h1000, 0, 32'h6000);
        acc(1, 0, 32'h1004, 0, 32'ha5506000);
        acc(0, 1, MB + 32'h2024, r, 0);
        acc(0, 0, MB + 32'h2024, 0, 0);
        n = n_fwd;
        acc(0, 1, MB + 32'h30000, r, 0);
        chk(n_fwd, n);
        acc(0, 1, MB + 32'h20d0, r, 0);
        chk({burst, wmark}, {r[9:8], r[5:0]});
        r = xs(r);
        ctx_rs <= 1'b1;
        arb_d <= r;
        iset <= r;
        @(posedge clk);
        ctx_rs <= 1'b0;
        iset <= 32'h0;
        acc(0, 0, MB + 32'h20e4, 0, r);
        chk(arb_state, r);
        acc(0, 0, MB + 32'h20a4, 0, r);
        acc(0, 1, MB + 32'h20a4, r, 0);
        acc(0, 0, MB + 32'h20a4, 0, 0);
        $display("registers done");
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
